// file: src/cbt_code_map.sv
// Maps 8-bit count codes to the count they select
`timescale 1ns/1ns
`default_nettype none
module cbt_code_map
(
  // Code in
  input wire logic [7:0] i_code,
  // Count out
  output logic [8:0] o_count
);
  import cbt_pkg::*;
  always_comb
  begin
    if (i_code == CODE_MAX)
      o_count = {1'b0, CODE_MAX};
    else
      o_count = {1'b0, i_code} + 9'h001;
  end
endmodule
`default_nettype wire

// file: src/cbt_pkg.sv
// Package of constants and types for the capacitive baseline tracker
package cbt_pkg;
  localparam int DATA_W = 10;
  localparam int ACC_W = 18;
  localparam logic [11:0] OFS_RISE_MPD = 12'h000;
  localparam logic [11:0] OFS_RISE_NSS = 12'h004;
  localparam logic [11:0] OFS_RISE_NRC = 12'h008;
  localparam logic [11:0] OFS_RISE_AVD = 12'h00c;
  localparam logic [11:0] OFS_FALL_MPD = 12'h010;
  localparam logic [11:0] OFS_FALL_NSS = 12'h014;
  localparam logic [11:0] OFS_FALL_NRC = 12'h018;
  localparam logic [11:0] OFS_FALL_AVD = 12'h01c;
  localparam logic [11:0] OFS_TOUCH_NSS = 12'h020;
  localparam logic [11:0] OFS_TOUCH_NRC = 12'h024;
  localparam logic [11:0] OFS_TOUCH_AVD = 12'h028;
  localparam logic [11:0] OFS_BASELINE = 12'h02c;
  localparam logic [11:0] OFS_STATUS = 12'h030;
  localparam int FIELD6_W = 6;
  localparam int FIELD8_W = 8;
  localparam logic [7:0] RST_MPD = 8'h01;
  localparam logic [7:0] RST_NSS = 8'h01;
  localparam logic [7:0] RST_NRC = 8'h00;
  localparam logic [7:0] RST_AVD = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hff;
  typedef enum logic [1:0] {COND_RISE, COND_FALL, COND_TOUCH} cbt_cond_e;
endpackage

// file: src/cbt_sync.sv
// Two-flop synchroniser with asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module cbt_sync
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Data
  input wire logic i_async,
  output logic o_sync
);
  logic stage1;
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      stage1 <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule
`default_nettype wire

// file: src/cbt_tracker.sv
// Baseline tracking filter with APB register access
`timescale 1ns/1ns
`default_nettype none
module cbt_tracker
#(
  parameter int DW = cbt_pkg::DATA_W
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Sample input
  input wire logic i_sample_valid,
  input wire logic [cbt_pkg::DATA_W-1:0] i_sample,
  input wire logic i_touch,
  // Baseline output
  output logic [cbt_pkg::DATA_W-1:0] o_baseline,
  output logic o_baseline_valid
);
  import cbt_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0] r_mpd;
    logic [7:0] r_nss;
    logic [7:0] r_nrc;
    logic [7:0] r_avd;
    logic [7:0] f_mpd;
    logic [7:0] f_nss;
    logic [7:0] f_nrc;
    logic [7:0] f_avd;
    logic [7:0] t_nss;
    logic [7:0] t_nrc;
    logic [7:0] t_avd;
    logic [DATA_W-1:0] baseline;
    logic [8:0] run_cnt;
    logic [8:0] avg_cnt;
    logic [ACC_W-1:0] acc;
    cbt_cond_e cond;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic bl_valid;
  } cbt_state_s;

  cbt_state_s st;
  cbt_state_s next_st;
  logic touch_sync;
  logic [7:0] sel_mpd;
  logic [7:0] sel_nss;
  logic [7:0] sel_nrc;
  logic [7:0] sel_avd;
  logic [8:0] run_limit;
  logic [8:0] avg_limit;
  logic [DATA_W-1:0] avg;
  logic [DATA_W:0] diff;
  logic [DATA_W:0] step;
  logic [DATA_W:0] pass_lim;
  logic [ACC_W-1:0] acc_sum;
  cbt_cond_e new_cond;
  logic apb_start;
  logic apb_done;
  logic rst_n_a;
  logic rst_n;

  // ****************************************
  // Reset release and touch synchroniser
  // ****************************************
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_n_a <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_n_a <= 1'b1;
      rst_n <= rst_n_a;
    end
  end

  cbt_sync u_touch_sync
  (
    .i_clock(i_clock),
    .i_reset_n(rst_n),
    .i_async(i_touch),
    .o_sync(touch_sync)
  );

  // ****************************************
  // Parameter set selection
  // ****************************************
  always_comb
  begin
    sel_mpd = st.r_mpd;
    sel_nss = st.r_nss;
    sel_nrc = st.r_nrc;
    sel_avd = st.r_avd;
    case (st.cond)
      COND_RISE:
      begin
        sel_mpd = st.r_mpd;
        sel_nss = st.r_nss;
        sel_nrc = st.r_nrc;
        sel_avd = st.r_avd;
      end
      COND_FALL:
      begin
        sel_mpd = st.f_mpd;
        sel_nss = st.f_nss;
        sel_nrc = st.f_nrc;
        sel_avd = st.f_avd;
      end
      COND_TOUCH:
      begin
        sel_mpd = 8'h00;
        sel_nss = st.t_nss;
        sel_nrc = st.t_nrc;
        sel_avd = st.t_avd;
      end
      default:
      begin
        sel_mpd = st.r_mpd;
      end
    endcase
  end

  cbt_code_map u_run_map
  (
    .i_code(sel_nrc),
    .o_count(run_limit)
  );

  cbt_code_map u_avg_map
  (
    .i_code(sel_avd),
    .o_count(avg_limit)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    next_st.bl_valid = 1'b0;
    acc_sum = st.acc + ACC_W'(i_sample);
    avg = DATA_W'(acc_sum / ACC_W'(avg_limit));
    pass_lim = (DATA_W+1)'({sel_mpd[FIELD6_W-1:0], 1'b0});
    step = (DATA_W+1)'(sel_nss[FIELD6_W-1:0]);
    if (touch_sync)
      new_cond = COND_TOUCH;
    else if (i_sample < st.baseline)
      new_cond = COND_FALL;
    else
      new_cond = COND_RISE;
    diff = '0;
    // ****************************************
    // Register access
    // ****************************************
    // Answer one cycle into the access phase; complete on the next edge
    apb_start = i_psel && i_penable && !st.pready;
    apb_done = i_psel && i_penable && st.pready;
    if (apb_start)
    begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      if (i_pwrite)
      begin
        case (i_paddr)
          OFS_RISE_MPD,
          OFS_RISE_NSS,
          OFS_RISE_NRC,
          OFS_RISE_AVD,
          OFS_FALL_MPD,
          OFS_FALL_NSS,
          OFS_FALL_NRC,
          OFS_FALL_AVD,
          OFS_TOUCH_NSS,
          OFS_TOUCH_NRC,
          OFS_TOUCH_AVD,
          OFS_BASELINE,
          OFS_STATUS: next_st.pslverr = 1'b0;
          default: next_st.pslverr = 1'b1;
        endcase
      end
      else
      begin
        case (i_paddr)
          OFS_RISE_MPD: next_st.prdata = {24'h000000, st.r_mpd};
          OFS_RISE_NSS: next_st.prdata = {24'h000000, st.r_nss};
          OFS_RISE_NRC: next_st.prdata = {24'h000000, st.r_nrc};
          OFS_RISE_AVD: next_st.prdata = {24'h000000, st.r_avd};
          OFS_FALL_MPD: next_st.prdata = {24'h000000, st.f_mpd};
          OFS_FALL_NSS: next_st.prdata = {24'h000000, st.f_nss};
          OFS_FALL_NRC: next_st.prdata = {24'h000000, st.f_nrc};
          OFS_FALL_AVD: next_st.prdata = {24'h000000, st.f_avd};
          OFS_TOUCH_NSS: next_st.prdata = {24'h000000, st.t_nss};
          OFS_TOUCH_NRC: next_st.prdata = {24'h000000, st.t_nrc};
          OFS_TOUCH_AVD: next_st.prdata = {24'h000000, st.t_avd};
          OFS_BASELINE: next_st.prdata = 32'(st.baseline);
          OFS_STATUS:
            next_st.prdata = {4'h0, st.avg_cnt, st.run_cnt,
                              8'h00, 2'(st.cond)};
          default: next_st.pslverr = 1'b1;
        endcase
      end
    end
    // ****************************************
    // Register write
    // ****************************************
    // Writes land only on the edge that completes the transfer
    if (apb_done && i_pwrite)
    begin
      case (i_paddr)
        OFS_RISE_MPD: next_st.r_mpd = {2'b00, i_pwdata[5:0]};
        OFS_RISE_NSS: next_st.r_nss = {2'b00, i_pwdata[5:0]};
        OFS_RISE_NRC: next_st.r_nrc = i_pwdata[7:0];
        OFS_RISE_AVD: next_st.r_avd = i_pwdata[7:0];
        OFS_FALL_MPD: next_st.f_mpd = {2'b00, i_pwdata[5:0]};
        OFS_FALL_NSS: next_st.f_nss = {2'b00, i_pwdata[5:0]};
        OFS_FALL_NRC: next_st.f_nrc = i_pwdata[7:0];
        OFS_FALL_AVD: next_st.f_avd = i_pwdata[7:0];
        OFS_TOUCH_NSS: next_st.t_nss = {2'b00, i_pwdata[5:0]};
        OFS_TOUCH_NRC: next_st.t_nrc = i_pwdata[7:0];
        OFS_TOUCH_AVD: next_st.t_avd = i_pwdata[7:0];
        default: next_st.pslverr = 1'b0;
      endcase
    end
    // ****************************************
    // Baseline filter
    // ****************************************
    // Baseline filter
    if (i_sample_valid)
    begin
      if (new_cond != st.cond)
      begin
        next_st.cond = new_cond;
        next_st.run_cnt = 9'h000;
        next_st.avg_cnt = 9'h000;
        next_st.acc = '0;
      end
      else if (st.avg_cnt + 9'h001 < avg_limit)
      begin
        next_st.avg_cnt = st.avg_cnt + 9'h001;
        next_st.acc = acc_sum;
      end
      else
      begin
        next_st.avg_cnt = 9'h000;
        next_st.acc = '0;
        next_st.bl_valid = 1'b1;
        if (avg >= st.baseline)
          diff = (DATA_W+1)'(avg - st.baseline);
        else
          diff = (DATA_W+1)'(st.baseline - avg);
        if (diff < pass_lim)
        begin
          next_st.baseline = avg;
          next_st.run_cnt = 9'h000;
        end
        else if (st.run_cnt + 9'h001 >= run_limit)
        begin
          next_st.run_cnt = 9'h000;
          if (avg > st.baseline)
            next_st.baseline = (diff < step) ? avg
              : DATA_W'(st.baseline + step[DATA_W-1:0]);
          else
            next_st.baseline = (diff < step) ? avg
              : DATA_W'(st.baseline - step[DATA_W-1:0]);
        end
        else
          next_st.run_cnt = st.run_cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.r_mpd <= RST_MPD;
      st.r_nss <= RST_NSS;
      st.r_nrc <= RST_NRC;
      st.r_avd <= RST_AVD;
      st.f_mpd <= RST_MPD;
      st.f_nss <= RST_NSS;
      st.f_nrc <= RST_NRC;
      st.f_avd <= RST_AVD;
      st.t_nss <= RST_NSS;
      st.t_nrc <= RST_NRC;
      st.t_avd <= RST_AVD;
      st.cond <= COND_RISE;
    end
    else
      st <= next_st;
  end

  // ****************************************
  // Outputs straight from the state register
  // ****************************************
  assign o_prdata = st.prdata;
  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;
  assign o_baseline = st.baseline;
  assign o_baseline_valid = st.bl_valid;
endmodule
`default_nettype wire

// file: verif/cbt_tracker_properties.sv
// Port-level property checker for the baseline tracker
`timescale 1ns/1ns
`default_nettype none
module cbt_tracker_properties
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // APB
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Samples and baseline
  input wire logic i_sample_valid,
  input wire logic [cbt_pkg::DATA_W-1:0] i_sample,
  input wire logic i_touch,
  input wire logic [cbt_pkg::DATA_W-1:0] o_baseline,
  input wire logic o_baseline_valid
);
  import cbt_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  property p_ready; i_psel && i_penable && !o_pready |=> o_pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready missing");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_rst; $rose(i_reset_n) |-> o_baseline == '0; endproperty
  a_rst: assert property (p_rst) else $error("baseline not cleared");
  property p_avg; $changed(o_baseline) |-> o_baseline_valid; endproperty
  a_avg: assert property (p_avg) else $error("baseline moved alone");
  property p_src; o_baseline_valid |-> $past(i_sample_valid); endproperty
  a_src: assert property (p_src) else $error("valid without sample");
  property p_fall; i_sample_valid && !i_touch && i_sample < o_baseline
    |=> o_baseline <= $past(o_baseline); endproperty
  a_fall: assert property (p_fall) else $error("falling raised");
  property p_rise; i_sample_valid && !i_touch && i_sample >= o_baseline
    |=> o_baseline >= $past(o_baseline); endproperty
  a_rise: assert property (p_rise) else $error("rising lowered");
  property p_step; $changed(o_baseline) |-> (o_baseline > $past(o_baseline)
    ? o_baseline - $past(o_baseline) : $past(o_baseline) - o_baseline) < 126;
  endproperty
  a_step: assert property (p_step) else $error("step too large");
  cover property (o_pslverr);
  cover property (i_sample_valid && i_touch);
  cover property (o_baseline_valid && $changed(o_baseline));
endmodule
bind cbt_tracker cbt_tracker_properties u_props
(
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_sample_valid(i_sample_valid),
  .i_sample(i_sample), .i_touch(i_touch), .o_baseline(o_baseline),
  .o_baseline_valid(o_baseline_valid)
);
`default_nettype wire

// file: verif/tb_capacitive_baseline_tracker.sv
// Self-checking testbench for the baseline tracker
`timescale 1ns/1ns
`default_nettype none
module tb_capacitive_baseline_tracker;
  import cbt_pkg::*;
  logic i_clock = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, i_sample_valid = 1'b0, i_touch = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata;
  logic [DATA_W-1:0] i_sample = '0, o_baseline;
  logic o_pready, o_pslverr, o_baseline_valid;
  logic [32:0] rd_q[$], bl_q[$];
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  int cfg[3][4], bl = 0, acc = 0, num = 0, run = 0;
  bit tch = 0;
  cbt_cond_e cnd = COND_RISE;
  cbt_tracker dut
  (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_sample_valid(i_sample_valid),
    .i_sample(i_sample), .i_touch(i_touch), .o_baseline(o_baseline),
    .o_baseline_valid(o_baseline_valid)
  );
  always #10 i_clock = ~i_clock;
  // ****************
  // Tasks
  // ****************
  function automatic int fld(int a);
    return a < 8 ? a % 4 : a - 7;
  endfunction
  function automatic int cn(int c);
    return c == 255 ? 255 : c + 1;
  endfunction
  task complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [32:0] e, input logic [32:0] s);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task smp(input int s);
    cbt_cond_e c;
    int a, d;
    c = tch ? COND_TOUCH : (s < bl ? COND_FALL : COND_RISE);
    i_sample <= DATA_W'(s);
    i_sample_valid <= 1'b1;
    if (c != cnd)
    begin
      cnd = c;
      acc = 0;
      num = 0;
      run = 0;
    end
    else
    begin
      acc += s;
      num++;
      if (num == cn(cfg[c][3]))
      begin
        a = acc / num;
        d = a > bl ? a - bl : bl - a;
        acc = 0;
        num = 0;
        if (c != COND_TOUCH && d < 2 * cfg[c][0])
        begin
          bl = a;
          run = 0;
        end
        else if (++run >= cn(cfg[c][2]))
        begin
          run = 0;
          bl += (a > bl ? 1 : -1) * (d < cfg[c][1] ? d : cfg[c][1]);
        end
        bl_q.push_back(33'(bl));
      end
    end
    @(posedge i_clock);
    i_sample_valid <= 1'b0;
    repeat (3) @(posedge i_clock);
  endtask
  task drift(input int k);
    int s;
    repeat (k)
    begin
      s = bl + int'($urandom % 90) - 40;
      if ($urandom % 8 == 0)
        s += ($urandom % 2) ? 300 : -300;
      smp(s < 0 ? 0 : s > 1023 ? 1023 : s);
    end
  endtask
  // ****************
  // Checking and sequence
  // ****************
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      error_cnt++;
      complete_run();
    end
    if (o_pready === 1'b1 && i_pwrite === 1'b0)
      chk("prdata", rd_q.pop_front(), {o_pslverr, o_prdata});
    if (o_baseline_valid === 1'b1)
      chk("baseline", bl_q.pop_front(), 33'(o_baseline));
  end
  initial
  begin
    logic [31:0] d;
    void'($urandom(61));
    repeat (12) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    for (int a = 0; a < 11; a++)
      rd(12'(4 * a), {25'h0, fld(a) < 2 ? RST_MPD : RST_NRC});
    rd(OFS_BASELINE, 33'h0);
    rd(12'h040, {1'b1, 32'h0});
    $display("test reset values done");
    for (int a = 0; a < 11; a++)
    begin
      d = $urandom;
      if (fld(a) < 2)
        d[5:0] = 6'(1 + $urandom % 63);
      else
        d[7:0] = 8'($urandom % 4);
      if (a == 7)
        d[7:0] = 8'(4 + $urandom % 4);
      cfg[a / 4][fld(a)] = d & (fld(a) < 2 ? 32'h3f : 32'hff);
      apb(1'b1, 12'(4 * a), d);
      rd(12'(4 * a), {1'b0, 32'(cfg[a / 4][fld(a)])});
    end
    $display("test configuration done");
    drift(300);
    $display("test tracking done");
    tch = 1'b1;
    i_touch <= 1'b1;
    repeat (4) @(posedge i_clock);
    drift(100);
    tch = 1'b0;
    i_touch <= 1'b0;
    repeat (4) @(posedge i_clock);
    drift(50);
    $display("test touch done");
    apb(1'b1, OFS_BASELINE, 32'h5a);
    rd(OFS_BASELINE, {1'b0, 32'(bl)});
    repeat (5) @(posedge i_clock);
    chk("queues", 33'h0, 33'(bl_q.size() + rd_q.size()));
    $display("test baseline readback done");
    complete_run();
  end
endmodule
`default_nettype wire
